// ---- sru_core_model.sv ----
/*
  Behavioural model of the core and break module facing the stop block.
  Assumes the bench requests stop and wake events one clock ahead.
*/
module sru_core_model
  import sru_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench requests
  input wire logic go_stop,
  input wire logic wake_go,
  input wire logic wake_brk,
  // Block answers and core requests
  input wire logic stack_start,
  output logic stop_exec,
  output logic module_irq,
  output logic break_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic served_reg;

  // A real requester keeps its level until the stacking it asked for starts.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      served_reg <= 1'b0;
    end else begin
      served_reg <= wake_go && (served_reg || stack_start);
    end
    stop_exec <= rstn && go_stop;
    module_irq <= rstn && wake_go && !wake_brk && !served_reg && !stack_start;
    break_irq <= rstn && wake_go && wake_brk && !served_reg && !stack_start;
  end
endmodule : sru_core_model

// ---- sru_pkg.sv ----
/*
  Package for the stop recovery and status block: register addresses,
  field positions, reset values, timing counts and shared types.
  Assumes a 16-bit register address and 8-bit register data.
*/
package sru_pkg;

  localparam logic [15:0] SRU_ADDR_BRK_STATUS = 16'hFE00;
  localparam logic [15:0] SRU_ADDR_RST_SOURCE = 16'hFE01;
  localparam logic [15:0] SRU_ADDR_BRK_CLR_CTRL = 16'hFE03;
  localparam logic [15:0] SRU_ADDR_IRQ_STATUS = 16'hFE08;
  localparam logic [15:0] SRU_ADDR_IRQ_MASK = 16'hFE09;

  localparam int SRU_BIT_BREAK_EXIT = 1;
  localparam int SRU_BIT_BREAK_CLEAR_EN = 1;
  localparam int SRU_BIT_POR = 7;
  localparam int SRU_BIT_PIN = 6;
  localparam int SRU_BIT_WDOG = 5;
  localparam int SRU_BIT_BADOP = 4;
  localparam int SRU_BIT_BADADR = 3;
  localparam int SRU_BIT_LVR = 1;
  localparam int SRU_EV_STOP_EXIT = 0;
  localparam int SRU_EV_BREAK_EXIT = 1;
  localparam int SRU_EV_RESET_SEEN = 2;

  localparam logic [7:0] SRU_BRK_STATUS_RST = 8'h00;
  localparam logic [7:0] SRU_BRK_CLR_CTRL_RST = 8'h00;
  localparam logic [7:0] SRU_RST_SOURCE_POR = 8'h80;
  localparam logic [7:0] SRU_IRQ_RST = 8'h00;

  localparam int SRU_LONG_RECOVERY_CYCLES = 4096;
  localparam int SRU_SHORT_RECOVERY_CYCLES = 32;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sru_bus_s;

  typedef struct packed {
    logic pin;
    logic wdog;
    logic badop;
    logic badadr;
    logic lvr;
  } sru_rst_cause_s;

  typedef enum logic [1:0] {
    SRU_RUN,
    SRU_STOPPED,
    SRU_RECOVER
  } sru_state_e;

endpackage : sru_pkg

// ---- sru_stop_recovery.sv ----
/*
  Stop-mode sequencer with recovery counter, break exit flag, reset source
  latch, break flag clear control and a small interrupt block.
  Assumes one 20 MHz clock (the reference oscillator clock), synchronous
  active-low reset, and that core, break and reset-cause signals are
  produced by logic on this same clock.
*/
// Functional notes
// - Stop entry clears counter, disables system clocks.
// - Interrupt exits stop; stacking after full delay.
// - Reset or break also ends stop.
// - Stop gates off system clock output.
// - Reference clock keeps feeding timebase in stop.
// - Delay 4096 cycles, or 32 when short.
// - Break ending stop sets break exit flag.
// - Break ending wait sets break exit flag.
// - Counter held reset until recovery, then times.
// - Registers at FE00, FE01 and FE03.
// - Exit flag bit 1, write zero clears.
// - Reading reset source clears all flags.
// - Power-on sets its flag, clears others.
// - Distinct flag per reset cause.
// - Break clear enable gates flag clearing in break.
// - Flag cleared in break stays cleared.
module sru_stop_recovery
  import sru_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Power-on indication, high for the first reset after power-up
  input wire logic por_event,
  // Reset causes, levels held for as long as rstn is low
  input wire sru_rst_cause_s rst_cause,
  // Core and break module
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic wait_active,
  input wire logic module_irq,
  input wire logic break_irq,
  input wire logic break_state,
  // Clock gating and core handshake
  output logic system_clock_enable,
  output logic timebase_clock_enable,
  output logic stack_start,
  output logic stopped,
  output logic flag_clear_allowed,
  // Register port
  input wire sru_bus_s bus,
  output logic [7:0] rdata,
  // Interrupt
  output logic irq
);

  function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
    hit = (a == base);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Stop sequencer.

  sru_state_e state_reg, state_next;
  logic [12:0] count_reg, count_next;
  logic break_exit_reg, break_exit_next;
  logic stop_exit_ev, break_exit_ev, wait_break_ev;
  logic [12:0] delay_len;
  logic short_stop_recovery_select;
  logic [7:0] brk_clr_reg, brk_clr_next;

  // The short delay bit lives in the control register, bit 0, since the
  // configuration register is outside this block.
  assign short_stop_recovery_select = brk_clr_reg[0];
  assign delay_len = short_stop_recovery_select ? 13'(SRU_SHORT_RECOVERY_CYCLES)
                                                : 13'(SRU_LONG_RECOVERY_CYCLES);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    stop_exit_ev = 1'b0;
    case (state_reg)
      SRU_RUN: begin
        if (stop_exec) begin
          state_next = SRU_STOPPED;
          count_next = 13'h0000;
        end
      end
      SRU_STOPPED: begin
        count_next = 13'h0000;
        if (module_irq || break_irq) begin
          state_next = SRU_RECOVER;
        end
      end
      SRU_RECOVER: begin
        count_next = count_reg + 13'h0001;
        if (count_reg == delay_len - 13'h0001) begin
          state_next = SRU_RUN;
          stop_exit_ev = 1'b1;
        end
      end
      default: begin
        state_next = SRU_RUN;
      end
    endcase
  end

  // A break that wakes the part from stop is remembered when the wake begins.
  assign break_exit_ev = (state_reg == SRU_STOPPED) && break_irq;
  assign wait_break_ev = wait_active && break_irq;

  always_comb begin
    break_exit_next = break_exit_reg;
    if (bus.wr && hit(bus.addr, SRU_ADDR_BRK_STATUS) && !bus.wdata[SRU_BIT_BREAK_EXIT]) begin
      break_exit_next = 1'b0;
    end
    if (break_exit_ev || wait_break_ev) begin
      break_exit_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= SRU_RUN;
      count_reg <= 13'h0000;
      break_exit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      break_exit_reg <= break_exit_next;
    end
  end

  assign system_clock_enable = (state_reg == SRU_RUN);
  assign timebase_clock_enable = 1'b1;
  assign stopped = (state_reg != SRU_RUN);
  assign stack_start = stop_exit_ev;

  //////////////////////////////////////////////////////////////////////////////
  // Reset source and break clear control.

  logic [7:0] rst_src_reg, rst_src_next;
  logic in_reset_reg;

  // Causes are gathered while reset is held, so the flags survive release;
  // the first cycle of a new reset wipes whatever the last one left.
  always_comb begin
    rst_src_next = rst_src_reg;
    if (!rstn) begin
      if (por_event) begin
        rst_src_next = SRU_RST_SOURCE_POR;
      end else begin
        if (!in_reset_reg) begin
          rst_src_next = 8'h00;
        end
        if (rst_cause.pin) begin
          rst_src_next[SRU_BIT_PIN] = 1'b1;
        end
        if (rst_cause.wdog) begin
          rst_src_next[SRU_BIT_WDOG] = 1'b1;
        end
        if (rst_cause.badop) begin
          rst_src_next[SRU_BIT_BADOP] = 1'b1;
        end
        if (rst_cause.badadr) begin
          rst_src_next[SRU_BIT_BADADR] = 1'b1;
        end
        if (rst_cause.lvr) begin
          rst_src_next[SRU_BIT_LVR] = 1'b1;
        end
      end
    end else if (bus.rd && hit(bus.addr, SRU_ADDR_RST_SOURCE)) begin
      rst_src_next = 8'h00;
    end
    brk_clr_next = brk_clr_reg;
    if (bus.wr && hit(bus.addr, SRU_ADDR_BRK_CLR_CTRL)) begin
      brk_clr_next = bus.wdata & 8'h83;
    end
  end

  always_ff @(posedge clk) begin
    rst_src_reg <= rst_src_next;
    if (!rstn) begin
      in_reset_reg <= 1'b1;
      brk_clr_reg <= SRU_BRK_CLR_CTRL_RST;
    end else begin
      in_reset_reg <= 1'b0;
      brk_clr_reg <= brk_clr_next;
    end
  end

  // Peripherals see this as a clear permit; a flag they clear stays clear
  // because nothing here restores it after the break ends.
  assign flag_clear_allowed = !break_state || brk_clr_reg[SRU_BIT_BREAK_CLEAR_EN];

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  logic [7:0] irq_stat_reg, irq_stat_next;
  logic [7:0] irq_mask_reg, irq_mask_next;
  logic [7:0] irq_set;

  always_comb begin
    irq_set = 8'h00;
    irq_set[SRU_EV_STOP_EXIT] = stop_exit_ev;
    irq_set[SRU_EV_BREAK_EXIT] = break_exit_ev || wait_break_ev;
    irq_set[SRU_EV_RESET_SEEN] = in_reset_reg;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    if (bus.wr && hit(bus.addr, SRU_ADDR_IRQ_STATUS)) begin
      irq_stat_next = irq_stat_reg & ~bus.wdata;
    end
    if (bus.wr && hit(bus.addr, SRU_ADDR_IRQ_MASK)) begin
      irq_mask_next = bus.wdata;
    end
    irq_stat_next = irq_stat_next | irq_set;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_stat_reg <= SRU_IRQ_RST;
      irq_mask_reg <= SRU_IRQ_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads return zero.

  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        SRU_ADDR_BRK_STATUS: rdata_next = {6'h00, break_exit_reg, 1'b0};
        SRU_ADDR_RST_SOURCE: rdata_next = rst_src_reg;
        SRU_ADDR_BRK_CLR_CTRL: rdata_next = brk_clr_reg;
        SRU_ADDR_IRQ_STATUS: rdata_next = irq_stat_reg;
        SRU_ADDR_IRQ_MASK: rdata_next = irq_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions, with an independent count of recovery cycles beside them.

  // The checker keeps its own count so that a fault in the sequencer's counter
  // cannot hide behind the same arithmetic.
  logic [12:0] chk_recover_reg, chk_recover_next;

  always_comb begin
    chk_recover_next = 13'h0000;
    if (state_reg == SRU_RECOVER) begin
      chk_recover_next = chk_recover_reg + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      chk_recover_reg <= 13'h0000;
    end else begin
      chk_recover_reg <= chk_recover_next;
    end
  end

  a_stop_gates_clock: assert property (@(posedge clk) disable iff (!rstn)
    stop_exec && state_reg == SRU_RUN |=> !system_clock_enable && count_reg == 13'h0000)
    else $error("stop entry did not gate clock");
  a_wake_moves: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_STOPPED && (module_irq || break_irq) |=> state_reg == SRU_RECOVER)
    else $error("wake request ignored");
  a_short_delay: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_reg == SRU_RECOVER) && short_stop_recovery_select && !bus.wr |-> ##31 stack_start)
    else $error("short recovery length wrong");
  a_long_delay: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_RECOVER && !short_stop_recovery_select
      && chk_recover_reg == 13'(SRU_LONG_RECOVERY_CYCLES - 1) |-> stack_start)
    else $error("long recovery length wrong");
  a_stack_window: assert property (@(posedge clk) disable iff (!rstn)
    stack_start |-> chk_recover_reg == (short_stop_recovery_select ? 13'(SRU_SHORT_RECOVERY_CYCLES - 1)
                                                                   : 13'(SRU_LONG_RECOVERY_CYCLES - 1)))
    else $error("stacking before delay elapsed");
  a_recover_holds: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_RECOVER && !stack_start |=> state_reg == SRU_RECOVER)
    else $error("recovery cut short");
  a_stack_pulse: assert property (@(posedge clk) disable iff (!rstn)
    stack_start |=> !stack_start && system_clock_enable)
    else $error("stack start not a single pulse");
  a_stop_holds: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_STOPPED && !module_irq && !break_irq |=> state_reg == SRU_STOPPED)
    else $error("stop left without a wake");
  a_clock_off_stop: assert property (@(posedge clk) disable iff (!rstn)
    state_reg != SRU_RUN |-> !system_clock_enable)
    else $error("clock running in stop");
  a_tb_clock_on: assert property (@(posedge clk) disable iff (!rstn)
    timebase_clock_enable)
    else $error("timebase clock stopped");
  a_break_exit_set: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_STOPPED && break_irq |=> break_exit_reg)
    else $error("break exit flag not set");
  a_wait_break_set: assert property (@(posedge clk) disable iff (!rstn)
    wait_active && break_irq |=> break_exit_reg)
    else $error("wait break flag not set");
  a_counter_held: assert property (@(posedge clk) disable iff (!rstn)
    state_reg == SRU_STOPPED |=> count_reg == 13'h0000)
    else $error("counter not held in stop");
  a_exit_clear: assert property (@(posedge clk) disable iff (!rstn)
    bus.wr && bus.addr == SRU_ADDR_BRK_STATUS && !bus.wdata[1] && !break_irq |=> !break_exit_reg)
    else $error("break exit flag not cleared");
  a_status_zero: assert property (@(posedge clk) disable iff (!rstn)
    bus.rd && bus.addr == SRU_ADDR_BRK_STATUS |=> rdata[7:2] == 6'h00 && !rdata[0])
    else $error("break status spare bits set");
  a_src_read_clr: assert property (@(posedge clk) disable iff (!rstn)
    bus.rd && bus.addr == SRU_ADDR_RST_SOURCE |=> rst_src_reg == 8'h00)
    else $error("reset source not cleared by read");
  a_read_data: assert property (@(posedge clk) disable iff (!rstn)
    bus.rd && bus.addr == SRU_ADDR_BRK_CLR_CTRL && !$past(bus.wr) |=> rdata == $past(brk_clr_reg))
    else $error("control read mismatch");
  a_clear_gate: assert property (@(posedge clk) disable iff (!rstn)
    break_state && !brk_clr_reg[SRU_BIT_BREAK_CLEAR_EN] |-> !flag_clear_allowed)
    else $error("clear allowed while protected");
  a_clear_open: assert property (@(posedge clk) disable iff (!rstn)
    !break_state |-> flag_clear_allowed)
    else $error("clear blocked outside break");

  // Capture checks run while reset is held, so they carry no disable.
  a_por_flag: assert property (@(posedge clk)
    !rstn && por_event |=> rst_src_reg == SRU_RST_SOURCE_POR)
    else $error("power-on flag not captured");
  a_pin_cause: assert property (@(posedge clk)
    !rstn && !por_event && rst_cause.pin |=> rst_src_reg[SRU_BIT_PIN])
    else $error("pin reset flag not captured");
  a_wdog_cause: assert property (@(posedge clk)
    !rstn && !por_event && rst_cause.wdog |=> rst_src_reg[SRU_BIT_WDOG])
    else $error("watchdog reset flag not captured");
  a_badop_cause: assert property (@(posedge clk)
    !rstn && !por_event && rst_cause.badop |=> rst_src_reg[SRU_BIT_BADOP])
    else $error("bad opcode flag not captured");
  a_badadr_cause: assert property (@(posedge clk)
    !rstn && !por_event && rst_cause.badadr |=> rst_src_reg[SRU_BIT_BADADR])
    else $error("bad fetch address flag not captured");
  a_lvr_cause: assert property (@(posedge clk)
    !rstn && !por_event && rst_cause.lvr |=> rst_src_reg[SRU_BIT_LVR])
    else $error("low voltage flag not captured");

endmodule : sru_stop_recovery

// ---- tb_top.sv ----
/*
  Self-checking bench for the stop recovery and status block.
  Assumes the core model file is compiled before this one.
*/
module tb_top
  import sru_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} sru_tb_row_s;
  sru_tb_row_s rows [5] = '{'{16'hFE03, 8'h83, 8'h83}, '{16'hFE03, 8'h00, 8'h00},
    '{16'hFE02, 8'hFF, 8'h00}, '{16'hFE09, 8'h02, 8'h02}, '{16'hFE00, 8'h00, 8'h00}};
  logic [7:0] cause_exp [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic por_event = 1'b0;
  logic wait_active = 1'b0;
  logic break_state = 1'b0;
  logic go_stop = 1'b0;
  logic wake_go = 1'b0;
  logic wake_brk = 1'b0;
  sru_rst_cause_s rst_cause = '0;
  sru_bus_s bus = '0;
  logic stop_exec, module_irq, break_irq, sys_en, tb_en, stack_start, stopped, fca, irq;
  logic [7:0] rdata;
  int failures = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  sru_core_model i_core (.clk(clk), .rstn(rstn), .go_stop(go_stop), .wake_go(wake_go), .wake_brk(wake_brk),
    .stack_start(stack_start), .stop_exec(stop_exec), .module_irq(module_irq), .break_irq(break_irq));

  sru_stop_recovery i_dut (.clk(clk), .rstn(rstn), .por_event(por_event), .rst_cause(rst_cause),
    .stop_exec(stop_exec), .wait_exec(1'b0), .wait_active(wait_active), .module_irq(module_irq),
    .break_irq(break_irq), .break_state(break_state), .system_clock_enable(sys_en),
    .timebase_clock_enable(tb_en), .stack_start(stack_start), .stopped(stopped),
    .flag_clear_allowed(fca), .bus(bus), .rdata(rdata), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 check(rdata, e);
  endtask : rd_chk

  task automatic do_reset(input logic por, input sru_rst_cause_s c);
    @(posedge clk) rstn <= 1'b0;
    por_event <= por;
    rst_cause <= c;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    por_event <= 1'b0;
    rst_cause <= '0;
  endtask : do_reset

  // Stays stopped longer than the short delay, so a counter running in stop shows.
  task automatic stop_run(input logic brk, input int len);
    int n;
    n = 0;
    @(posedge clk) go_stop <= 1'b1;
    @(posedge clk) go_stop <= 1'b0;
    repeat (40) @(posedge clk);
    #1 check(sys_en, 8'h00);
    check(tb_en, 8'h01);
    check(stopped, 8'h01);
    @(posedge clk) wake_brk <= brk;
    wake_go <= 1'b1;
    while (stack_start !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 5000) begin
      failures++;
      close_out();
    end
    check(8'(n >= len && n <= len + 4), 8'h01);
    @(posedge clk) wake_go <= 1'b0;
    #1 check(sys_en, 8'h01);
    check(stopped, 8'h00);
  endtask : stop_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b1, '0);
    rd_chk(16'hFE01, 8'h80);
    rd_chk(16'hFE01, 8'h00);
    for (int i = 0; i < 5; i++) begin
      do_reset(1'b0, sru_rst_cause_s'(5'h10 >> i));
      rd_chk(16'hFE01, cause_exp[i]);
    end
    $display("test reset sources done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    $display("test register rows done");
    wr(16'hFE03, 8'h01);
    stop_run(1'b0, 32);
    rd_chk(16'hFE00, 8'h00);
    rd_chk(16'hFE08, 8'h05);
    #1 check(irq, 8'h00);
    wr(16'hFE03, 8'h00);
    stop_run(1'b1, 4096);
    rd_chk(16'hFE00, 8'h02);
    check(irq, 8'h01);
    wr(16'hFE08, 8'h02);
    #1 check(irq, 8'h00);
    wr(16'hFE00, 8'h00);
    rd_chk(16'hFE00, 8'h00);
    $display("test stop recovery done");
    @(posedge clk) wait_active <= 1'b1;
    wake_brk <= 1'b1;
    wake_go <= 1'b1;
    repeat (4) @(posedge clk);
    wake_go <= 1'b0;
    wait_active <= 1'b0;
    rd_chk(16'hFE00, 8'h02);
    @(posedge clk) break_state <= 1'b1;
    @(posedge clk);
    #1 check(fca, 8'h00);
    wr(16'hFE03, 8'h02);
    #1 check(fca, 8'h01);
    wr(16'hFE00, 8'h00);
    break_state <= 1'b0;
    rd_chk(16'hFE00, 8'h00);
    $display("test break handling done");
    close_out();
  end
endmodule : tb_top
